/* File: hw/jdc_counter.sv */
// Divide-by-eight Johnson counter with paired clock qualifiers and decoded outputs.
`timescale 1ns/100ps
`default_nettype none
module jdc_counter (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic master_clear,
    input wire logic rise_clock_in,
    input wire logic fall_clock_in_n,
    output logic [jdc_pkg::STATES-1:0] state_decode_outs,
    output logic upper_half_carry_n
);
    // Three-stage pin synchronisers; a change counts when stages two and three agree.
    logic [jdc_pkg::SYNC_DEPTH-1:0] rise_sync_q, rise_sync_d;
    logic [jdc_pkg::SYNC_DEPTH-1:0] fall_sync_q, fall_sync_d;
    logic [jdc_pkg::SYNC_DEPTH-1:0] clr_sync_q, clr_sync_d;
    jdc_pkg::jdc_pins_type pins_q, pins_d;
    logic [jdc_pkg::STAGES-1:0] stage_q, stage_d;
    logic [jdc_pkg::STATES-1:0] decode_q, decode_d;
    logic carry_n_q, carry_n_d;
    logic clear_now;
    logic clr_filt_q, clr_filt_d;
    logic advance;

    // Map the Johnson pattern to a one-hot state index.
    function automatic logic [jdc_pkg::STATES-1:0] decode_state(
        input logic [jdc_pkg::STAGES-1:0] s);
        logic [jdc_pkg::STATES-1:0] r;
        r = '0;
        case (s)
            4'h0: r = 8'h01;
            4'h1: r = 8'h02;
            4'h3: r = 8'h04;
            4'h7: r = 8'h08;
            4'hf: r = 8'h10;
            4'he: r = 8'h20;
            4'hc: r = 8'h40;
            4'h8: r = 8'h80;
            default: r = 8'h01;
        endcase
        return r;
    endfunction

    // Filtered clear; the raw pin already clears through the async path, and this copy keeps
    // the counter at zero until a released clear has settled on the clock.
    assign clear_now = clr_filt_q;

    // Shift the pins in and accept a level only once two later stages agree.
    always_comb begin
        rise_sync_d = {rise_sync_q[1:0], rise_clock_in};
        fall_sync_d = {fall_sync_q[1:0], fall_clock_in_n};
        clr_sync_d = {clr_sync_q[1:0], master_clear};
        pins_d = pins_q;
        if (rise_sync_q[1] == rise_sync_q[2]) begin
            pins_d.rise_clk = rise_sync_q[2];
        end
        if (fall_sync_q[1] == fall_sync_q[2]) begin
            pins_d.fall_clk_n = fall_sync_q[2];
        end
        clr_filt_d = clr_filt_q;
        if (clr_sync_q[1] == clr_sync_q[2]) begin
            clr_filt_d = clr_sync_q[2];
        end
    end

    // Qualified edge detection on filtered levels; both forms are a gated pair.
    always_comb begin
        advance = 1'b0;
        if (pins_d.rise_clk && !pins_q.rise_clk && !pins_q.fall_clk_n) begin
            advance = 1'b1;
        end
        if (!pins_d.fall_clk_n && pins_q.fall_clk_n && pins_q.rise_clk) begin
            advance = 1'b1;
        end
    end

    // Johnson shift with the inverted top stage fed back; decode is registered so no glitch.
    always_comb begin
        stage_d = stage_q;
        if (clear_now) begin
            stage_d = jdc_pkg::RESET_STAGES;
        end else if (advance) begin
            stage_d = {stage_q[2:0], ~stage_q[jdc_pkg::TOP_STAGE]};
        end
        decode_d = decode_state(stage_d);
        carry_n_d = ~stage_d[jdc_pkg::TOP_STAGE];
    end

    // Master clear resets asynchronously, as does the system reset; constants only.
    always_ff @(posedge sys_clk or negedge nrst or posedge master_clear) begin
        if (!nrst || master_clear) begin
            stage_q <= jdc_pkg::RESET_STAGES;
            decode_q <= jdc_pkg::RESET_DECODE;
            carry_n_q <= jdc_pkg::RESET_CARRY_N;
        end else begin
            stage_q <= stage_d;
            decode_q <= decode_d;
            carry_n_q <= carry_n_d;
        end
    end

    // Synchronisers run independently of master clear so edges after clear are seen cleanly.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rise_sync_q <= '0;
            fall_sync_q <= '1;
            clr_sync_q <= '0;
            clr_filt_q <= 1'b0;
            pins_q <= '{rise_clk: 1'b0, fall_clk_n: 1'b1};
        end else begin
            rise_sync_q <= rise_sync_d;
            fall_sync_q <= fall_sync_d;
            clr_sync_q <= clr_sync_d;
            clr_filt_q <= clr_filt_d;
            pins_q <= pins_d;
        end
    end

    // Outputs come straight from their flip-flops, so a state change shows as one clean step.
    assign state_decode_outs = decode_q;
    assign upper_half_carry_n = carry_n_q;

    // Plain binary count of the state index, kept apart from the Johnson stages so that the
    // decode is checked against an independent model rather than against itself.
    logic [2:0] ref_state_q, ref_state_d;
    always_comb begin
        ref_state_d = ref_state_q;
        if (clear_now) begin
            ref_state_d = 3'h0;
        end else if (advance) begin
            ref_state_d = ref_state_q + 3'h1;
        end
    end

    // The reference clears exactly like the counter, asynchronously on either reset.
    always_ff @(posedge sys_clk or negedge nrst or posedge master_clear) begin
        if (!nrst || master_clear) begin
            ref_state_q <= 3'h0;
        end else begin
            ref_state_q <= ref_state_d;
        end
    end

    // Helper: previous decode, for step checks.
    logic [jdc_pkg::STATES-1:0] prev_decode_q;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prev_decode_q <= jdc_pkg::RESET_DECODE;
        end else begin
            prev_decode_q <= decode_q;
        end
    end

    // One qualified advance with no clear pending.
    sequence s_step;
        !master_clear && !clear_now && advance;
    endsequence

    // Filtered pin movements; each refusal check pairs one of them with a qualifier level or with the other pin held steady.
    sequence s_rise_up;
        pins_d.rise_clk && !pins_q.rise_clk;
    endsequence
    sequence s_rise_down;
        !pins_d.rise_clk && pins_q.rise_clk;
    endsequence
    sequence s_fall_down;
        !pins_d.fall_clk_n && pins_q.fall_clk_n;
    endsequence
    sequence s_fall_up;
        pins_d.fall_clk_n && !pins_q.fall_clk_n;
    endsequence

    // State and output checks; each names the rule it guards in its label and its error message.
    a_decode_onehot: assert property (@(posedge sys_clk) disable iff (!nrst)
        $onehot(state_decode_outs))
        else $error("decode outputs not one-hot");
    a_step_next: assert property (@(posedge sys_clk) disable iff (!nrst || master_clear)
        s_step |=> (decode_q == {prev_decode_q[6:0], prev_decode_q[7]}))
        else $error("counter did not step by one");
    a_hold_idle: assert property (@(posedge sys_clk) disable iff (!nrst || master_clear)
        (!advance && !clear_now) |=> $stable(stage_q))
        else $error("state changed without qualified edge");
    a_rise_adv: assert property (@(posedge sys_clk) disable iff (!nrst || master_clear)
        (pins_d.rise_clk && !pins_q.rise_clk && !pins_q.fall_clk_n && !clear_now)
            |=> stage_q != $past(stage_q))
        else $error("rising qualified edge ignored");
    a_fall_adv: assert property (@(posedge sys_clk) disable iff (!nrst || master_clear)
        (!pins_d.fall_clk_n && pins_q.fall_clk_n && pins_q.rise_clk && !clear_now)
            |=> stage_q != $past(stage_q))
        else $error("falling qualified edge ignored");
    a_clear_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        master_clear |-> (state_decode_outs == 8'h01 && upper_half_carry_n))
        else $error("clear did not force state zero");
    a_carry_upper: assert property (@(posedge sys_clk) disable iff (!nrst)
        upper_half_carry_n == (state_decode_outs[3:0] != 4'h0))
        else $error("carry does not match upper half");
    a_johnson_legal: assert property (@(posedge sys_clk) disable iff (!nrst)
        decode_state(stage_q) == decode_q && (stage_q inside {4'h0, 4'h1, 4'h3, 4'h7,
            4'hf, 4'he, 4'hc, 4'h8}))
        else $error("illegal Johnson pattern");

    // The decode must follow the independent count, which also proves the eight-step wrap.
    a_ref_match: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_decode_outs == (8'h01 << ref_state_q))
        else $error("decode does not follow the state count");
    a_clear_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        clear_now |=> (stage_q == jdc_pkg::RESET_STAGES))
        else $error("counter left zero while clear was pending");
    a_carry_top: assert property (@(posedge sys_clk) disable iff (!nrst)
        upper_half_carry_n == !stage_q[jdc_pkg::TOP_STAGE])
        else $error("carry is not the inverted top stage");

    // Opposite edges and edges without their qualifier must leave the state alone.
    a_rise_drop: assert property (@(posedge sys_clk) disable iff (!nrst || master_clear)
        (s_rise_down ##0 (pins_d.fall_clk_n == pins_q.fall_clk_n) ##0 !clear_now)
            |=> $stable(stage_q))
        else $error("falling rise input moved the state");
    a_rise_ungated: assert property (@(posedge sys_clk) disable iff (!nrst || master_clear)
        (s_rise_up ##0 pins_q.fall_clk_n ##0 !clear_now) |=> $stable(stage_q))
        else $error("rise edge counted with the qualifier high");
    a_fall_lift: assert property (@(posedge sys_clk) disable iff (!nrst || master_clear)
        (s_fall_up ##0 (pins_d.rise_clk == pins_q.rise_clk) ##0 !clear_now)
            |=> $stable(stage_q))
        else $error("rising fall input moved the state");
    a_fall_ungated: assert property (@(posedge sys_clk) disable iff (!nrst || master_clear)
        (s_fall_down ##0 !pins_q.rise_clk ##0 !clear_now) |=> $stable(stage_q))
        else $error("fall edge counted with the qualifier low");
endmodule
`default_nettype wire

/* File: hw/jdc_pkg.sv */
// Package of constants and types for the divide-by-eight Johnson counter.
package jdc_pkg;
    localparam int unsigned STAGES = 4;
    localparam int unsigned STATES = 8;
    localparam int unsigned SYNC_DEPTH = 3;
    localparam logic [STAGES-1:0] RESET_STAGES = 4'h0;
    localparam logic [STATES-1:0] RESET_DECODE = 8'h01;
    localparam logic RESET_CARRY_N = 1'b1;
    localparam int unsigned TOP_STAGE = 3;

    // Sampled pin levels after the input filter.
    typedef struct packed {
        logic rise_clk;
        logic fall_clk_n;
    } jdc_pins_type;
endpackage

/* File: verification/jdc_cascade_model.sv */
// Following counter stage that is clocked by the carry output.
`timescale 1ns/100ps
`default_nettype none
module jdc_cascade_model (
    input wire logic sys_clk,
    input wire logic carry_n
);
    int unsigned stage_count = 0;
    logic prev_q = 1'b1;
    // A rise of the carry advances the next stage, so it steps once per full cycle.
    always @(posedge sys_clk) begin
        if (carry_n === 1'b1 && prev_q === 1'b0) begin
            stage_count++;
        end
        prev_q <= carry_n;
    end
endmodule
`default_nettype wire

/* File: verification/jdc_counter_tb.sv */
// Self-checking bench for the divide-by-eight Johnson counter.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module jdc_counter_tb;
    logic sys_clk, nrst, master_clear, rise_clock_in, fall_clock_in_n;
    logic [jdc_pkg::STATES-1:0] state_decode_outs;
    logic upper_half_carry_n;
    int err_count = 0;
    int num_checks = 0;
    int exp_state = 0;
    int base;
    jdc_counter DUT (.sys_clk(sys_clk), .nrst(nrst), .master_clear(master_clear),
        .rise_clock_in(rise_clock_in), .fall_clock_in_n(fall_clock_in_n),
        .state_decode_outs(state_decode_outs), .upper_half_carry_n(upper_half_carry_n));
    jdc_cascade_model PEER (.sys_clk(sys_clk), .carry_n(upper_half_carry_n));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Pins move off the sampling edge and then wait out synchroniser and filter.
    task automatic drive(input logic r, input logic f, input logic mc);
        @(negedge sys_clk);
        rise_clock_in = r;
        fall_clock_in_n = f;
        master_clear = mc;
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic chk_state();
        `CHK(state_decode_outs, 8'h01 << exp_state)
        `CHK(upper_half_carry_n, (exp_state < 4) ? 1'b1 : 1'b0)
    endtask
    // Rising edges count with the other pin low; falling edges must not.
    task automatic test_rise(input int n);
        for (int i = 0; i < n; i++) begin
            drive(1'b1, 1'b0, 1'b0);
            exp_state = (exp_state + 1) % 8;
            chk_state();
            drive(1'b0, 1'b0, 1'b0);
            chk_state();
        end
    endtask
    // Falling edges count only while the rising input sits high.
    task automatic test_fall();
        drive(1'b0, 1'b1, 1'b0);
        chk_state();
        drive(1'b1, 1'b1, 1'b0);
        chk_state();
        for (int i = 0; i < 8; i++) begin
            drive(1'b1, 1'b0, 1'b0);
            exp_state = (exp_state + 1) % 8;
            chk_state();
            drive(1'b1, 1'b1, 1'b0);
            chk_state();
        end
        drive(1'b0, 1'b1, 1'b0);
        chk_state();
        drive(1'b0, 1'b0, 1'b0);
        chk_state();
    endtask
    // Clear from an upper state; a clock edge during the clear is ignored.
    task automatic test_clear();
        test_rise(5);
        drive(1'b0, 1'b0, 1'b1);
        exp_state = 0;
        chk_state();
        drive(1'b1, 1'b0, 1'b1);
        chk_state();
        drive(1'b0, 1'b0, 1'b0);
        chk_state();
        test_rise(1);
    endtask
    // Power-up reset leaves state zero with the carry high.
    task automatic test_reset();
        nrst = 1'b0;
        master_clear = 1'b0;
        rise_clock_in = 1'b0;
        fall_clock_in_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (4) @(negedge sys_clk);
        exp_state = 0;
        chk_state();
    endtask
    // One full turn of the counter gives the following stage exactly one step.
    task automatic test_cascade();
        base = PEER.stage_count;
        test_rise(8);
        `CHK(PEER.stage_count - base, 1)
    endtask
    // A system reset in mid-count returns to zero, and counting resumes after it.
    task automatic test_mid_reset();
        test_rise(3);
        @(negedge sys_clk);
        nrst = 1'b0;
        repeat (2) @(negedge sys_clk);
        nrst = 1'b1;
        exp_state = 0;
        repeat (4) @(negedge sys_clk);
        chk_state();
        test_rise(1);
    endtask
    task automatic test_done();
        $display("Checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        test_done();
    end
    initial begin
        test_reset();
        test_cascade();
        test_fall();
        test_clear();
        test_mid_reset();
        test_done();
    end
endmodule
`default_nettype wire
